// ==== system_clock_source_select.sv ====
// System clock source selection: APB registers, prescaler, PLL control
// and a glitch-free switch between four sampled clock sources.
// Assumes every source level is sampled by clock well below its Nyquist rate.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select #(
   parameter int PRESC_W = 10,
   parameter int P_W = 4,
   parameter int N_W = 7,
   parameter int OUT_DIV_W = 7
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock sources, sampled levels
   input wire logic ext_clock_input_pin,
   input wire logic osc_clock_in,
   input wire logic wakeup_clock_in,
   input wire logic vco_clock_in,
   // PLL control
   output logic pll_enable_q,
   output logic pll_ref_internal_q,
   output logic [1:0] vco_band_select_q,
   output logic [P_W-1:0] pll_input_div_q,
   output logic [N_W-1:0] pll_mult_q,
   // System clock
   output logic system_clock_q,
   output logic clock_switching
);

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [1:0] clock_source_select_q;
   logic vco_bypass_q;
   logic [P_W-1:0] pll_input_div_field_q;
   logic [N_W-1:0] pll_mult_field_q;
   logic [OUT_DIV_W-1:0] pll_output_div_field_q;
   logic [PRESC_W-1:0] prescaler_div_field_q;
   logic [31:0] prdata_q;

   clock_select_pkg::source_t want;
   clock_select_pkg::source_t active_q;
   clock_select_pkg::switch_state_t state_q;
   logic presc_level;
   logic pll_level;
   logic [3:0] src_level;
   logic sel_level;
   logic wr_en;
   logic setup;
   logic hit;

   // Map selection and bypass to a source; reserved code 01 falls to wakeup
   function automatic clock_select_pkg::source_t want_src(input logic [1:0] sel,
                                                         input logic bypass);
      clock_select_pkg::source_t s;
      s = clock_select_pkg::SRC_WAKEUP;
      case (sel)
         clock_select_pkg::SEL_DIRECT: s = clock_select_pkg::SRC_EXT;
         clock_select_pkg::SEL_PLL_PATH: begin
            s = bypass ? clock_select_pkg::SRC_PRESC : clock_select_pkg::SRC_PLL;
         end
         default: s = clock_select_pkg::SRC_WAKEUP;
      endcase
      return s;
   endfunction

   // Address decode shared by writes and the error answer
   function automatic logic mapped(input logic [11:0] a);
      return (a == clock_select_pkg::SYS_CTRL_OFFSET) ||
             (a == clock_select_pkg::PLL_CFG_OFFSET) ||
             (a == clock_select_pkg::PRESC_OFFSET);
   endfunction

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   // Zero wait states; unmapped accesses answer with pslverr
   assign setup = psel && !penable;
   assign hit = mapped(paddr);
   assign wr_en = psel && penable && pwrite && hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_q;

   // Control writes; software orders them to avoid bad intermediate setups
   always_ff @(posedge clock) begin
      if (reset) begin
         clock_source_select_q <= clock_select_pkg::SEL_RESET;
         vco_bypass_q <= clock_select_pkg::BYPASS_RESET;
         pll_ref_internal_q <= clock_select_pkg::REF_RESET;
         vco_band_select_q <= clock_select_pkg::BAND_LOW;
         pll_input_div_field_q <= '0;
         pll_mult_field_q <= '0;
         pll_output_div_field_q <= '0;
         prescaler_div_field_q <= '0;
      end else if (wr_en) begin
         case (paddr)
            clock_select_pkg::SYS_CTRL_OFFSET: begin
               clock_source_select_q <= pwdata[clock_select_pkg::SEL_LSB +: 2];
            end
            clock_select_pkg::PLL_CFG_OFFSET: begin
               vco_bypass_q <= pwdata[clock_select_pkg::BYPASS_BIT];
               vco_band_select_q <= pwdata[clock_select_pkg::BAND_LSB +: 2];
               pll_ref_internal_q <= pwdata[clock_select_pkg::REF_BIT];
               pll_input_div_field_q <= pwdata[clock_select_pkg::IN_DIV_LSB +: P_W];
               pll_mult_field_q <= pwdata[clock_select_pkg::MULT_LSB +: N_W];
               pll_output_div_field_q <= pwdata[clock_select_pkg::OUT_DIV_LSB +: OUT_DIV_W];
            end
            clock_select_pkg::PRESC_OFFSET: begin
               prescaler_div_field_q <= pwdata[clock_select_pkg::PRESC_LSB +: PRESC_W];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data captured in the setup cycle, stable through the access
   always_ff @(posedge clock) begin
      if (reset) begin
         prdata_q <= '0;
      end else if (setup) begin
         prdata_q <= '0;
         case (paddr)
            clock_select_pkg::SYS_CTRL_OFFSET: begin
               prdata_q[clock_select_pkg::SEL_LSB +: 2] <= clock_source_select_q;
               prdata_q[clock_select_pkg::ACTIVE_LSB +: 2] <= active_q;
               prdata_q[clock_select_pkg::SWITCHING_BIT] <= clock_switching;
            end
            clock_select_pkg::PLL_CFG_OFFSET: begin
               prdata_q[clock_select_pkg::BYPASS_BIT] <= vco_bypass_q;
               prdata_q[clock_select_pkg::BAND_LSB +: 2] <= vco_band_select_q;
               prdata_q[clock_select_pkg::REF_BIT] <= pll_ref_internal_q;
               prdata_q[clock_select_pkg::IN_DIV_LSB +: P_W] <= pll_input_div_field_q;
               prdata_q[clock_select_pkg::MULT_LSB +: N_W] <= pll_mult_field_q;
               prdata_q[clock_select_pkg::OUT_DIV_LSB +: OUT_DIV_W] <= pll_output_div_field_q;
            end
            clock_select_pkg::PRESC_OFFSET: begin
               prdata_q[clock_select_pkg::PRESC_LSB +: PRESC_W] <= prescaler_div_field_q;
            end
            default: begin
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // PLL control and dividers
   // -----------------------------------------------------------------
   // Gain N/(P*output factor): P and N go to the analogue loop,
   // the output factor is divided here
   always_ff @(posedge clock) begin
      if (reset) begin
         pll_enable_q <= 1'b0;
         pll_input_div_q <= '0;
         pll_mult_q <= '0;
      end else begin
         pll_enable_q <= (want == clock_select_pkg::SRC_PLL);
         pll_input_div_q <= pll_input_div_field_q;
         pll_mult_q <= pll_mult_field_q;
      end
   end

   // Prescaler on the oscillator, factors 1 to 1024
   edge_divider #(
      .W(PRESC_W)
   ) u_prescaler (
      .clock(clock),
      .reset(reset),
      .src_level(osc_clock_in),
      .div_field(prescaler_div_field_q),
      .div_level_q(presc_level)
   );

   // Output divider on the VCO
   edge_divider #(
      .W(OUT_DIV_W)
   ) u_pll_out_div (
      .clock(clock),
      .reset(reset),
      .src_level(vco_clock_in),
      .div_field(pll_output_div_field_q),
      .div_level_q(pll_level)
   );

   // -----------------------------------------------------------------
   // Glitch-free source switch
   // -----------------------------------------------------------------
   assign want = want_src(clock_source_select_q, vco_bypass_q);
   assign src_level = {ext_clock_input_pin, pll_level, presc_level, wakeup_clock_in};
   assign sel_level = src_level[active_q];
   assign clock_switching = (state_q != clock_select_pkg::ST_RUN);

   // Leave the old source only when low, join the new one only when low,
   // so the output low phase stretches instead of being cut short
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= clock_select_pkg::ST_RUN;
         active_q <= clock_select_pkg::SRC_WAKEUP;
         system_clock_q <= 1'b0;
      end else begin
         case (state_q)
            clock_select_pkg::ST_RUN: begin
               system_clock_q <= sel_level;
               if (want != active_q && !sel_level) begin
                  state_q <= clock_select_pkg::ST_PARK;
               end
            end
            clock_select_pkg::ST_PARK: begin
               system_clock_q <= 1'b0;
               active_q <= want;
               state_q <= clock_select_pkg::ST_JOIN;
            end
            clock_select_pkg::ST_JOIN: begin
               system_clock_q <= 1'b0;
               if (!sel_level) begin
                  state_q <= clock_select_pkg::ST_RUN;
               end
            end
            default: begin
               state_q <= clock_select_pkg::ST_RUN;
               system_clock_q <= 1'b0;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_old_source_low;
      (state_q == clock_select_pkg::ST_RUN) && (want != active_q) && !sel_level;
   endsequence

   sequence s_held_low;
      !system_clock_q [*2];
   endsequence

   property p_park_entry;
      @(posedge clock) disable iff (reset)
         s_old_source_low |=> (state_q == clock_select_pkg::ST_PARK) ##0 s_held_low;
   endproperty
   a_park_entry: assert property (p_park_entry) else $error("switch left source badly");

   property p_join_low;
      @(posedge clock) disable iff (reset)
         (state_q == clock_select_pkg::ST_JOIN) |-> !system_clock_q;
   endproperty
   a_join_low: assert property (p_join_low) else $error("clock high while joining");

   property p_run_follow;
      @(posedge clock) disable iff (reset)
         !$past(reset) && (state_q == clock_select_pkg::ST_RUN) &&
         $past(state_q == clock_select_pkg::ST_RUN)
         |-> system_clock_q == $past(sel_level);
   endproperty
   a_run_follow: assert property (p_run_follow) else $error("clock not following source");

   property p_want_ext;
      @(posedge clock) disable iff (reset)
         clock_source_select_q == clock_select_pkg::SEL_DIRECT
         |-> want == clock_select_pkg::SRC_EXT;
   endproperty
   a_want_ext: assert property (p_want_ext) else $error("direct drive not chosen");

   property p_want_presc;
      @(posedge clock) disable iff (reset)
         (clock_source_select_q == clock_select_pkg::SEL_PLL_PATH) && vco_bypass_q
         |-> want == clock_select_pkg::SRC_PRESC;
   endproperty
   a_want_presc: assert property (p_want_presc) else $error("prescaler not chosen");

   property p_want_pll;
      @(posedge clock) disable iff (reset)
         (clock_source_select_q == clock_select_pkg::SEL_PLL_PATH) && !vco_bypass_q
         |=> pll_enable_q;
   endproperty
   a_want_pll: assert property (p_want_pll) else $error("pll not enabled");

   property p_want_wake;
      @(posedge clock) disable iff (reset)
         clock_source_select_q == clock_select_pkg::SEL_WAKEUP
         |-> want == clock_select_pkg::SRC_WAKEUP;
   endproperty
   a_want_wake: assert property (p_want_wake) else $error("wakeup not chosen");

   property p_band;
      @(posedge clock) disable iff (reset)
         wr_en && (paddr == clock_select_pkg::PLL_CFG_OFFSET)
         |=> vco_band_select_q == $past(pwdata[2:1]);
   endproperty
   a_band: assert property (p_band) else $error("band field not stored");

   property p_pll_ratio;
      @(posedge clock) disable iff (reset)
         $past(pll_mult_field_q) == pll_mult_field_q ##0
         $past(pll_input_div_field_q) == pll_input_div_field_q
         |=> (pll_mult_q == $past(pll_mult_field_q)) &&
         (pll_input_div_q == $past(pll_input_div_field_q));
   endproperty
   a_pll_ratio: assert property (p_pll_ratio) else $error("pll ratio not forwarded");

endmodule
`default_nettype wire

// ==== clock_select_pkg.sv ====
// Constants for the system clock source selection and divider block.
// Assumes a single 20 MHz bus clock that oversamples every clock source.
package clock_select_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [11:0] SYS_CTRL_OFFSET = 12'h000;
   localparam logic [11:0] PLL_CFG_OFFSET = 12'h004;
   localparam logic [11:0] PRESC_OFFSET = 12'h008;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int SEL_LSB = 0;
   localparam int ACTIVE_LSB = 8;
   localparam int SWITCHING_BIT = 12;
   localparam int BYPASS_BIT = 0;
   localparam int BAND_LSB = 1;
   localparam int REF_BIT = 3;
   localparam int IN_DIV_LSB = 4;
   localparam int MULT_LSB = 8;
   localparam int OUT_DIV_LSB = 16;
   localparam int PRESC_LSB = 0;

   // -----------------------------------------------------------------
   // Selection codes and reset values
   // -----------------------------------------------------------------
   localparam logic [1:0] SEL_WAKEUP = 2'h0;
   localparam logic [1:0] SEL_PLL_PATH = 2'h2;
   localparam logic [1:0] SEL_DIRECT = 2'h3;
   localparam logic [1:0] BAND_LOW = 2'h0;
   localparam logic [1:0] BAND_HIGH = 2'h1;
   localparam logic [1:0] SEL_RESET = SEL_WAKEUP;
   localparam logic BYPASS_RESET = 1'b1;
   localparam logic REF_RESET = 1'b1;

   // Internal source index used by the glitch-free switch
   typedef enum logic [1:0] {
      SRC_WAKEUP = 2'h0,
      SRC_PRESC = 2'h1,
      SRC_PLL = 2'h2,
      SRC_EXT = 2'h3
   } source_t;

   // Switch states, one-hot
   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_PARK = 3'h2,
      ST_JOIN = 3'h4
   } switch_state_t;

endpackage

// ==== edge_divider.sv ====
// Divides a sampled clock level by (factor field + 1).
// Assumes src_level is sampled by clock, well below half the clock rate.
`timescale 1ns/1ps
`default_nettype none
module edge_divider #(
   parameter int W = 10
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Source and setting
   input wire logic src_level,
   input wire logic [W-1:0] div_field,
   // Divided level
   output logic div_level_q
);

   logic src_q;
   logic [W-1:0] cnt_q;
   logic rise;
   logic [W:0] half;

   assign rise = src_level && !src_q;
   // High for ceil(K/2) source periods of every K
   assign half = ({1'b0, div_field} + {{W{1'b0}}, 1'b1} + {{W{1'b0}}, 1'b1}) >> 1;

   // Edge history
   always_ff @(posedge clock) begin
      if (reset) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_level;
      end
   end

   // Count source periods, wrap after K of them
   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (div_field == '0) begin
         cnt_q <= '0;
      end else if (rise) begin
         cnt_q <= (cnt_q == div_field) ? '0 : cnt_q + 1'b1;
      end
   end

   // Factor one copies the source so its duty cycle survives
   always_ff @(posedge clock) begin
      if (reset) begin
         div_level_q <= 1'b0;
      end else if (div_field == '0) begin
         div_level_q <= src_level;
      end else if (rise) begin
         div_level_q <= ({1'b0, cnt_q} < half);
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_div_pass;
      @(posedge clock) disable iff (reset)
         !$past(reset) && (div_field == '0) && $past(div_field == '0)
         |-> div_level_q == $past(src_level);
   endproperty
   a_div_pass: assert property (p_div_pass) else $error("factor one not passed through");

   property p_div_wrap;
      @(posedge clock) disable iff (reset)
         rise && (div_field != '0) && (cnt_q == div_field) && $stable(div_field)
         |=> cnt_q == '0;
   endproperty
   a_div_wrap: assert property (p_div_wrap) else $error("divider count did not wrap");

endmodule
`default_nettype wire

// ==== test_system_clock_source_select.sv ====
// Self-checking bench for the system clock source selection block.
// Assumes a zero-wait APB slave and source levels made from the bench clock.
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_source_select;

   // ------------------------------------------------------------
   // Signals and register addresses
   // ------------------------------------------------------------
   localparam logic [11:0] a_ctrl = clock_select_pkg::SYS_CTRL_OFFSET;
   localparam logic [11:0] a_pll = clock_select_pkg::PLL_CFG_OFFSET;
   localparam logic [11:0] a_presc = clock_select_pkg::PRESC_OFFSET;
   logic clock, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic ext_clock_input_pin, osc_clock_in, wakeup_clock_in, vco_clock_in;
   logic pll_enable_q, pll_ref_internal_q, system_clock_q, clock_switching, last_clk;
   logic [1:0] vco_band_select_q;
   logic [3:0] pll_input_div_q;
   logic [6:0] pll_mult_q;
   int n_fail, tests_run, cyc, run_len;

   system_clock_source_select dut (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clock_input_pin(ext_clock_input_pin), .osc_clock_in(osc_clock_in),
      .wakeup_clock_in(wakeup_clock_in), .vco_clock_in(vco_clock_in),
      .pll_enable_q(pll_enable_q), .pll_ref_internal_q(pll_ref_internal_q),
      .vco_band_select_q(vco_band_select_q), .pll_input_div_q(pll_input_div_q),
      .pll_mult_q(pll_mult_q), .system_clock_q(system_clock_q),
      .clock_switching(clock_switching)
   );

   // ------------------------------------------------------------
   // Clock, source levels and timeout
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Distinct half periods (3, 2, 7, 5) so each path shows its own period
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc % 3 == 0) ext_clock_input_pin <= ~ext_clock_input_pin;
      if (cyc % 2 == 0) osc_clock_in <= ~osc_clock_in;
      if (cyc % 7 == 0) wakeup_clock_in <= ~wakeup_clock_in;
      if (cyc % 5 == 0) vco_clock_in <= ~vco_clock_in;
      if (cyc == 40000) begin
         n_fail = n_fail + 1;
         $display("ERROR at %0t: run did not finish in time", $time);
         report_and_stop();
      end
   end

   // Runt watch: every source phase lasts two samples or more, so a shorter
   // phase on the system clock can only come from a bad switch
   always @(negedge clock) begin
      if (reset) begin
         run_len = 2;
         last_clk = system_clock_q;
      end else if (system_clock_q !== last_clk) begin
         if (run_len < 2) check(32'(run_len), 32'h2);
         run_len = 1;
         last_clk = system_clock_q;
      end else begin
         run_len = run_len + 1;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
      logic [31:0] r;
      logic e;
      apb(1'b1, addr, wdata, r, e);
   endtask

   task automatic rd(input logic [11:0] addr, output logic [31:0] r);
      logic e;
      apb(1'b0, addr, 32'h0, r, e);
   endtask

   // Poll until the switch has landed; a slow old source can hold it off long
   task automatic wait_active(input logic [1:0] exp);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         rd(a_ctrl, r);
         n++;
      end while ((r[9:8] !== exp || r[12] !== 1'b0) && n < 1500);
      check(32'(r[12:8]), 32'(exp));
      check(32'(clock_switching), 32'h0);
   endtask

   // Whole period and high time of the system clock, in bench cycles
   task automatic measure(output int per, output int hi);
      int rises, n;
      logic prev;
      rises = 0;
      n = 0;
      per = 0;
      hi = 0;
      prev = system_clock_q;
      while (rises < 2 && n < 12000) begin
         @(negedge clock);
         n++;
         if (rises == 1) per++;
         if (rises == 1 && system_clock_q === 1'b1) hi++;
         if (system_clock_q === 1'b1 && prev === 1'b0) rises++;
         prev = system_clock_q;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_reset();
      logic [31:0] r;
      logic e;
      int per, hi;
      check(32'(pll_enable_q), 32'h0);
      check(32'(pll_ref_internal_q), 32'h1);
      check(32'(vco_band_select_q), 32'(clock_select_pkg::BAND_LOW));
      rd(a_pll, r);
      check(r, 32'h0000_0009);
      rd(a_presc, r);
      check(r, 32'h0);
      // Status fields are read-only
      wr(a_ctrl, 32'h0000_1f00);
      rd(a_ctrl, r);
      check(r, 32'h0);
      apb(1'b1, 12'h00c, 32'hffff_ffff, r, e);
      check(32'(e), 32'h1);
      apb(1'b0, 12'h00c, 32'h0, r, e);
      check({r[31:1], e}, 32'h1);
      measure(per, hi);
      check(32'(per), 32'd14);
      check(32'(hi), 32'd7);
      $display("test_reset done");
   endtask

   task automatic test_direct();
      int per, hi;
      wr(a_ctrl, 32'h0000_0003);
      wait_active(clock_select_pkg::SRC_EXT);
      measure(per, hi);
      check(32'(per), 32'd6);
      check(32'(hi), 32'd3);
      $display("test_direct done");
   endtask

   task automatic test_presc();
      int per, hi;
      // Divider and bypass first, selection last, so no PLL stage shows
      wr(a_presc, 32'h0);
      wr(a_pll, 32'h0000_0009);
      wr(a_ctrl, 32'h0000_0002);
      wait_active(clock_select_pkg::SRC_PRESC);
      check(32'(pll_enable_q), 32'h0);
      measure(per, hi);
      check(32'(per), 32'd4);
      check(32'(hi), 32'd2);
      wr(a_presc, 32'h0000_0002);
      measure(per, hi);
      measure(per, hi);
      check(32'(per), 32'd12);
      check(32'(hi), 32'd8);
      wr(a_presc, 32'h0000_03ff);
      measure(per, hi);
      measure(per, hi);
      check(32'(per), 32'd4096);
      check(32'(hi), 32'd2048);
      $display("test_presc done");
   endtask

   task automatic test_pll();
      logic [31:0] r;
      int per, hi;
      // Output factor one first: entering pass-through mid-run could cut a phase
      // P-1 2, N-1 5, output factor one, low band, external reference
      wr(a_pll, 32'h0000_0520);
      wait_active(clock_select_pkg::SRC_PLL);
      check(32'(pll_enable_q), 32'h1);
      check(32'({pll_input_div_q, pll_mult_q}), 32'h0000_0105);
      rd(a_pll, r);
      check(r, 32'h0000_0520);
      check(32'({pll_ref_internal_q, vco_band_select_q}), 32'h0);
      measure(per, hi);
      measure(per, hi);
      check(32'(per), 32'd10);
      check(32'(hi), 32'd5);
      // Output factor three, on-chip reference, high band
      wr(a_pll, 32'h0002_052a);
      measure(per, hi);
      measure(per, hi);
      check(32'({pll_ref_internal_q, vco_band_select_q}), 32'h5);
      check(32'(per), 32'd30);
      check(32'(hi), 32'd20);
      $display("test_pll done");
   endtask

   task automatic test_wakeup();
      logic [31:0] r;
      int per, hi;
      // Reserved code 01 lands on the wakeup source as well
      wr(a_ctrl, 32'h1);
      wait_active(clock_select_pkg::SRC_WAKEUP);
      rd(a_ctrl, r);
      check(r, 32'h0000_0001);
      wr(a_ctrl, 32'h0);
      wait_active(clock_select_pkg::SRC_WAKEUP);
      check(32'(pll_enable_q), 32'h0);
      measure(per, hi);
      check(32'(per), 32'd14);
      check(32'(hi), 32'd7);
      $display("test_wakeup done");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      ext_clock_input_pin = 1'b0;
      osc_clock_in = 1'b0;
      wakeup_clock_in = 1'b0;
      vco_clock_in = 1'b0;
      cyc = 0;
      n_fail = 0;
      tests_run = 0;
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      test_reset();
      test_direct();
      test_presc();
      test_pll();
      test_wakeup();
      report_and_stop();
   end

endmodule
`default_nettype wire
